// ===== transfer_ctrl_core.sv
// What this block does
// RULE_01: Stop bit set halts the controller after the current bus cycle.
// RULE_02: Writing 1 to the stop bit is ignored while an activation runs.
// RULE_03: Stop register loads 3FFF on reset and hardware standby only.
// RULE_04: Each activation reads descriptor, moves data, writes descriptor back.
// RULE_05: Chain enable set continues with the next descriptor in one activation.
// RULE_06: 24-bit source and destination each step up, down or stay fixed.
// RULE_07: Normal mode moves one byte or word per request, 65,536 count.
// RULE_08: Repeat mode restores addresses and count after 1 to 256 transfers.
// RULE_09: Block mode moves a 1 to 256 unit block per request.
// RULE_10: Repeating block area sits on source or destination side, selectable.
// RULE_11: Start on an enabled interrupt or a software vector write.
// RULE_12: Interrupt goes to controller when enable bit is 1, else CPU.
// RULE_13: Flag or enable clearing only after the final transfer of a chain.
// RULE_14: Soft start clears its enable if continuing; else holds, CPU interrupt.
// RULE_15: Interrupt start continuing clears source flag, keeps enable bit.
// RULE_16: Select bit or count end clears enable, keeps flag, CPU interrupt.
// RULE_17: Routed interrupts start the controller regardless of CPU masking.
// RULE_18: Simultaneous requests are served in fixed priority order.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module transfer_ctrl_core
#(
    parameter int N_SRC = 8
)
(
    input  wire logic                                I_CORE_CLK,
    input  wire logic                                I_RESET,
    input  wire logic                                I_CE,
    input  wire logic                                I_HW_STANDBY,
    input  wire logic                                I_PSEL,
    input  wire logic                                I_PENABLE,
    input  wire logic                                I_PWRITE,
    input  wire logic [transfer_ctrl_pkg::PADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]                         I_PWDATA,
    output logic      [31:0]                         O_PRDATA,
    output logic                                     O_PREADY,
    output logic                                     O_PSLVERR,
    input  wire logic [N_SRC-1:0]                    I_INT_REQ,
    output logic      [N_SRC-1:0]                    O_CPU_INT,
    output logic      [N_SRC-1:0]                    O_SRC_CLR,
    output logic                                     O_MEM_REQ,
    output logic                                     O_MEM_WE,
    output logic                                     O_MEM_WORD,
    output logic      [transfer_ctrl_pkg::ADDR_W-1:0] O_MEM_ADDR,
    output logic      [15:0]                         O_MEM_WDATA,
    input  wire logic                                I_MEM_ACK,
    input  wire logic [15:0]                         I_MEM_RDATA,
    output logic                                     O_IRQ,
    output logic                                     O_BUSY
);
    import transfer_ctrl_pkg::*;

    localparam int SRC_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;

    state_t           state;
    logic [15:0]      mstop;
    logic [N_SRC-1:0] enable;
    logic [7:0]       swvec;
    logic             swae_seen;
    logic             sw_pend;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  mask;
    logic [7:0]       mra;
    logic [7:0]       mrb;
    logic [23:0]      source_address;
    logic [23:0]      destination_address;
    logic [15:0]      cra;
    logic [15:0]      crb;
    logic [23:0]      desc_ptr;
    logic [2:0]       widx;
    logic [15:0]      dbuf;
    logic             sw_act;
    logic [SRC_W-1:0] src_idx;
    logic             fin_cpu;
    logic [N_SRC-1:0] en_clr;
    logic             swae_clr;
    logic [EV_W-1:0]  events;
    logic             acc;
    logic             wr_fire;
    logic             rd_fire;
    logic             hit;
    logic [31:0]      rd_val;
    logic             any_req;
    logic [SRC_W-1:0] pick;
    logic             stop_bit;
    logic             busy;
    logic [23:0]      delta;
    logic [23:0]      total;
    logic [8:0]       rep_cnt;
    logic [23:0]      sar_step;
    logic [23:0]      dar_step;
    logic             wrap;
    logic [15:0]      wb_word;
    logic [6:0]       vec_num;

    function automatic logic [23:0] step_addr(input logic [23:0] a,
                                              input logic [1:0]  md,
                                              input logic [23:0] d);
        if (md == 2'b10)
            return a + d;
        else if (md == 2'b11)
            return a - d;
        else
            return a;
    endfunction : step_addr

    assign stop_bit = mstop[MSTOP_TC_BIT];
    assign busy     = (state != ST_IDLE);
    assign acc      = I_PSEL && I_PENABLE;
    assign wr_fire  = acc && O_PREADY && I_PWRITE;
    assign rd_fire  = acc && O_PREADY && !I_PWRITE;

    always_comb
    begin
        hit    = 1'b1;
        rd_val = 32'h00000000;
        unique case (I_PADDR)
            OFF_MSTOP:  rd_val[15:0]       = mstop;
            OFF_ENABLE: rd_val[N_SRC-1:0]  = enable;
            OFF_SWVEC:  rd_val[7:0]        = swvec;
            OFF_STATUS: rd_val[EV_W-1:0]   = status;
            OFF_MASK:   rd_val[EV_W-1:0]   = mask;
            OFF_STATE:  rd_val[4:0]        = {stop_bit, busy, state};
            default:    hit                = 1'b0;
        endcase
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end
        else if (I_CE)
        begin
            O_PREADY  <= acc && !O_PREADY;
            O_PSLVERR <= acc && !O_PREADY && !hit;
            if (acc && !O_PREADY)
                O_PRDATA <= rd_val;
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET || I_HW_STANDBY)
            mstop <= MSTOP_RST; // RULE_03
        else if (I_CE && wr_fire && I_PADDR == OFF_MSTOP)
        begin
            mstop <= I_PWDATA[15:0];
            if (busy)
                mstop[MSTOP_TC_BIT] <= mstop[MSTOP_TC_BIT] & I_PWDATA[MSTOP_TC_BIT]; // RULE_02
        end
    end

    // Activation enables; a software write wins over a hardware clear
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET || I_HW_STANDBY)
            enable <= '0;
        else if (I_CE)
        begin
            if (wr_fire && I_PADDR == OFF_ENABLE)
                enable <= I_PWDATA[N_SRC-1:0];
            else
                enable <= enable & ~en_clr; // RULE_16
        end
    end

    // Software vector: 1 always writable, 0 only after 1 was read
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET || I_HW_STANDBY)
        begin
            swvec     <= 8'h00;
            swae_seen <= 1'b0;
            sw_pend   <= 1'b0;
        end
        else if (I_CE)
        begin
            if (swae_clr)
                swvec[SWV_EN_BIT] <= 1'b0; // RULE_14
            if (rd_fire && I_PADDR == OFF_SWVEC)
                swae_seen <= swvec[SWV_EN_BIT];
            if (wr_fire && I_PADDR == OFF_SWVEC)
            begin
                swvec[6:0] <= I_PWDATA[6:0];
                if (I_PWDATA[SWV_EN_BIT] || swae_seen)
                    swvec[SWV_EN_BIT] <= I_PWDATA[SWV_EN_BIT];
                sw_pend   <= I_PWDATA[SWV_EN_BIT]; // RULE_11
                swae_seen <= 1'b0;
            end
            else if (state == ST_IDLE && sw_pend && !stop_bit)
                sw_pend <= 1'b0;
        end
    end

    // Sticky status cleared by read; new events win
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            status <= '0;
            mask   <= '0;
            O_IRQ  <= 1'b0;
        end
        else if (I_CE)
        begin
            if (rd_fire && I_PADDR == OFF_STATUS)
                status <= events;
            else
                status <= status | events;
            if (wr_fire && I_PADDR == OFF_MASK)
                mask <= I_PWDATA[EV_W-1:0];
            O_IRQ <= |(status & mask);
        end
    end

    // Routing of each request to CPU or controller
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
            O_CPU_INT <= '0;
        else if (I_CE)
            O_CPU_INT <= I_INT_REQ & ~enable; // RULE_12
    end

    // Fixed priority: lowest index first
    always_comb
    begin
        any_req = 1'b0;
        pick    = '0;
        for (int i = N_SRC - 1; i >= 0; i--)
        begin
            if (I_INT_REQ[i] && enable[i]) // RULE_17
            begin
                any_req = 1'b1;
                pick    = SRC_W'(i); // RULE_18
            end
        end
    end

    // Address stepping and repeat area restore
    always_comb
    begin
        delta    = mra[MRA_SZ] ? 24'h000002 : 24'h000001;
        rep_cnt  = (cra[15:8] == 8'h00) ? 9'h100 : {1'b0, cra[15:8]};
        total    = mra[MRA_SZ] ? {14'h0000, rep_cnt, 1'b0}
                               : {15'h0000, rep_cnt};
        wrap     = (mra[3:2] != MODE_NORMAL) && (cra[7:0] == 8'h01);
        sar_step = step_addr(source_address, mra[7:6], delta); // RULE_06
        dar_step = step_addr(destination_address, mra[5:4], delta); // RULE_06
        if (wrap && mra[MRA_DTS])
            sar_step = step_addr(sar_step, {mra[7], ~mra[6]}, total); // RULE_10
        if (wrap && !mra[MRA_DTS])
            dar_step = step_addr(dar_step, {mra[5], ~mra[4]}, total); // RULE_10
        vec_num  = VEC_SRC_FIRST + 7'(src_idx);
        if (sw_act)
            vec_num = swvec[6:0];
        unique case (widx)
            3'h0:    wb_word = {mra, source_address[23:16]};
            3'h1:    wb_word = source_address[15:0];
            3'h2:    wb_word = {mrb, destination_address[23:16]};
            3'h3:    wb_word = destination_address[15:0];
            3'h4:    wb_word = cra;
            default: wb_word = crb;
        endcase
    end

    // Activation sequencer and memory port
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            state       <= ST_IDLE;
            O_MEM_REQ   <= 1'b0;
            O_MEM_WE    <= 1'b0;
            O_MEM_WORD  <= 1'b0;
            O_MEM_ADDR  <= '0;
            O_MEM_WDATA <= 16'h0000;
            O_SRC_CLR   <= '0;
            O_BUSY      <= 1'b0;
            mra         <= 8'h00;
            mrb         <= 8'h00;
            source_address         <= '0;
            destination_address         <= '0;
            cra         <= 16'h0000;
            crb         <= 16'h0000;
            desc_ptr    <= '0;
            widx        <= 3'h0;
            dbuf        <= 16'h0000;
            sw_act      <= 1'b0;
            src_idx     <= '0;
            fin_cpu     <= 1'b0;
            en_clr      <= '0;
            swae_clr    <= 1'b0;
            events      <= '0;
        end
        else if (I_CE)
        begin
            O_SRC_CLR <= '0;
            en_clr    <= '0;
            swae_clr  <= 1'b0;
            events    <= '0;
            O_BUSY    <= (state != ST_IDLE) && (state != ST_FIN);
            if (O_MEM_REQ && I_MEM_ACK)
                O_MEM_REQ <= 1'b0;
            else if (!O_MEM_REQ && !stop_bit && state != ST_IDLE
                     && state != ST_FIN) // RULE_01
            begin
                O_MEM_REQ  <= 1'b1;
                O_MEM_WE   <= (state == ST_WR) || (state == ST_WB);
                O_MEM_WORD <= (state != ST_RD && state != ST_WR)
                              || mra[MRA_SZ];
                O_MEM_WDATA <= (state == ST_WR) ? dbuf : wb_word;
                unique case (state)
                    ST_VEC:  O_MEM_ADDR <= {8'h00,
                                 VEC_BASE + {8'h00, vec_num, 1'b0}};
                    ST_RD:   O_MEM_ADDR <= source_address;
                    ST_WR:   O_MEM_ADDR <= destination_address;
                    default: O_MEM_ADDR <= desc_ptr + {20'h00000, widx, 1'b0};
                endcase
            end
            unique case (state)
                ST_IDLE:
                begin
                    if (!stop_bit && sw_pend)
                    begin
                        sw_act <= 1'b1;
                        state  <= ST_VEC; // RULE_11
                    end
                    else if (!stop_bit && any_req)
                    begin
                        sw_act  <= 1'b0;
                        src_idx <= pick; // RULE_18
                        state   <= ST_VEC;
                    end
                end
                ST_VEC:
                begin
                    if (O_MEM_REQ && I_MEM_ACK)
                    begin
                        desc_ptr <= {DESC_BANK, I_MEM_RDATA};
                        widx     <= 3'h0;
                        state    <= ST_DESC; // RULE_04
                    end
                end
                ST_DESC:
                begin
                    if (O_MEM_REQ && I_MEM_ACK)
                    begin
                        unique case (widx)
                            3'h0:
                            begin
                                mra        <= I_MEM_RDATA[15:8];
                                source_address[23:16] <= I_MEM_RDATA[7:0];
                            end
                            3'h1:    source_address[15:0] <= I_MEM_RDATA;
                            3'h2:
                            begin
                                mrb        <= I_MEM_RDATA[15:8];
                                destination_address[23:16] <= I_MEM_RDATA[7:0];
                            end
                            3'h3:    destination_address[15:0] <= I_MEM_RDATA;
                            3'h4:    cra <= I_MEM_RDATA;
                            default: crb <= I_MEM_RDATA;
                        endcase
                        widx <= widx + 3'h1;
                        if (widx == DESC_LAST)
                            state <= ST_RD;
                    end
                end
                ST_RD:
                begin
                    if (O_MEM_REQ && I_MEM_ACK)
                    begin
                        dbuf  <= I_MEM_RDATA;
                        state <= ST_WR;
                    end
                end
                ST_WR:
                begin
                    if (O_MEM_REQ && I_MEM_ACK)
                    begin
                        source_address   <= sar_step;
                        destination_address   <= dar_step;
                        widx  <= 3'h0;
                        state <= ST_WB;
                        unique case (mra[3:2])
                            MODE_REPEAT:
                            begin
                                cra[7:0] <= wrap ? cra[15:8]
                                                 : cra[7:0] - 8'h01; // RULE_08
                                fin_cpu  <= mrb[MRB_INTERRUPT_SELECT_BIT];
                            end
                            MODE_BLOCK:
                            begin
                                cra[7:0] <= wrap ? cra[15:8]
                                                 : cra[7:0] - 8'h01;
                                if (wrap)
                                    crb <= crb - 16'h0001;
                                else
                                    state <= ST_RD; // RULE_09
                                fin_cpu <= mrb[MRB_INTERRUPT_SELECT_BIT]
                                           || (crb == 16'h0001);
                            end
                            default:
                            begin
                                cra     <= cra - 16'h0001; // RULE_07
                                fin_cpu <= mrb[MRB_INTERRUPT_SELECT_BIT]
                                           || (cra == 16'h0001);
                            end
                        endcase
                    end
                end
                ST_WB:
                begin
                    if (O_MEM_REQ && I_MEM_ACK)
                    begin
                        widx <= widx + 3'h1;
                        if (widx == DESC_LAST && mrb[MRB_CHAIN_ENABLE])
                        begin
                            desc_ptr <= desc_ptr + DESC_BYTES; // RULE_05
                            widx     <= 3'h0;
                            state    <= ST_DESC;
                        end
                        else if (widx == DESC_LAST)
                        begin
                            state            <= ST_FIN; // RULE_13
                            events[EV_DONE]  <= 1'b1;
                            if (sw_act && !fin_cpu)
                                swae_clr <= 1'b1; // RULE_14
                            else if (sw_act)
                                events[EV_SWCPU] <= 1'b1; // RULE_14
                            else if (!fin_cpu)
                                O_SRC_CLR[src_idx] <= 1'b1; // RULE_15
                            else
                            begin
                                en_clr[src_idx] <= 1'b1; // RULE_16
                                events[EV_CPU]  <= 1'b1;
                            end
                        end
                    end
                end
                ST_FIN:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule : transfer_ctrl_core

// ===== transfer_ctrl_pkg.sv
package transfer_ctrl_pkg;
    localparam int          ADDR_W        = 24;
    localparam int          PADDR_W       = 8;
    localparam logic [7:0]  OFF_MSTOP     = 8'h00;
    localparam logic [7:0]  OFF_ENABLE    = 8'h04;
    localparam logic [7:0]  OFF_SWVEC     = 8'h08;
    localparam logic [7:0]  OFF_STATUS    = 8'h0C;
    localparam logic [7:0]  OFF_MASK      = 8'h10;
    localparam logic [7:0]  OFF_STATE     = 8'h14;
    localparam logic [15:0] MSTOP_RST     = 16'h3FFF;
    // High stop byte bit 6
    localparam int          MSTOP_TC_BIT  = 14;
    localparam int          SWV_EN_BIT    = 7;
    localparam logic [15:0] VEC_BASE      = 16'h0400;
    localparam logic [6:0]  VEC_SRC_FIRST = 7'h10;
    localparam logic [7:0]  DESC_BANK     = 8'hFF;
    localparam logic [2:0]  DESC_LAST     = 3'h5;
    localparam logic [23:0] DESC_BYTES    = 24'h00000C;
    localparam int          MRA_SM        = 6;
    localparam int          MRA_DM        = 4;
    localparam int          MRA_MODE      = 2;
    localparam int          MRA_DTS       = 1;
    localparam int          MRA_SZ        = 0;
    localparam int          MRB_CHAIN_ENABLE      = 7;
    localparam int          MRB_INTERRUPT_SELECT_BIT     = 6;
    localparam int          EV_DONE       = 0;
    localparam int          EV_SWCPU      = 1;
    localparam int          EV_CPU        = 2;
    localparam int          EV_W          = 3;

    typedef enum logic [1:0]
    {
        MODE_NORMAL = 2'b00,
        MODE_REPEAT = 2'b01,
        MODE_BLOCK  = 2'b10
    } mode_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_VEC  = 3'b001,
        ST_DESC = 3'b011,
        ST_RD   = 3'b010,
        ST_WR   = 3'b110,
        ST_WB   = 3'b111,
        ST_FIN  = 3'b101
    } state_t;
endpackage : transfer_ctrl_pkg

// ===== transfer_ctrl_core_sva.sv
`timescale 1ns/1ps
module transfer_ctrl_core_sva
#(
    parameter int N_SRC = 8
)
(
    input wire logic             I_CORE_CLK,
    input wire logic             I_RESET,
    input wire logic             I_PSEL,
    input wire logic             I_PENABLE,
    input wire logic             O_PREADY,
    input wire logic             O_PSLVERR,
    input wire logic [N_SRC-1:0] I_INT_REQ,
    input wire logic [N_SRC-1:0] O_CPU_INT,
    input wire logic [N_SRC-1:0] O_SRC_CLR,
    input wire logic             O_MEM_REQ,
    input wire logic             O_MEM_WORD,
    input wire logic [23:0]      O_MEM_ADDR,
    input wire logic             I_MEM_ACK
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);
    sequence access_start;
        $rose(I_PSEL && I_PENABLE);
    endsequence
    sequence mem_wait;
        O_MEM_REQ && !I_MEM_ACK;
    endsequence
    a_ready_after_access: assert property (access_start |=> O_PREADY)
        else $error("no ready");
    a_ready_one_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held");
    a_slverr_with_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("lone slverr");
    a_req_holds_addr: assert property (mem_wait |=> O_MEM_REQ && $stable(O_MEM_ADDR))
        else $error("request dropped");
    a_gap_after_ack: assert property (O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
        else $error("no gap");
    a_cpu_route_req: assert property (O_CPU_INT != '0 |-> (O_CPU_INT & ~$past(I_INT_REQ)) == '0)
        else $error("stray cpu int");
    a_clear_one_pulse: assert property (O_SRC_CLR != '0 |=> O_SRC_CLR == '0)
        else $error("clear held");
    a_word_aligned: assert property (O_MEM_REQ && O_MEM_WORD |-> !O_MEM_ADDR[0])
        else $error("odd address");
endmodule : transfer_ctrl_core_sva
bind transfer_ctrl_core transfer_ctrl_core_sva #(.N_SRC(N_SRC)) u_sva
(
    .I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_INT_REQ(I_INT_REQ), .O_CPU_INT(O_CPU_INT), .O_SRC_CLR(O_SRC_CLR),
    .O_MEM_REQ(O_MEM_REQ), .O_MEM_WORD(O_MEM_WORD),
    .O_MEM_ADDR(O_MEM_ADDR), .I_MEM_ACK(I_MEM_ACK)
);

// ===== xfer_mem_model.sv
`timescale 1ns/1ps
module xfer_mem_model
(
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [23:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic [15:0]      o_rdata
);
    logic [15:0] mem [int];
    int          cnt = 0;
    initial o_ack = 1'b0;
    initial o_rdata = 16'h0000;
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack && cnt < i_delay)
            cnt <= cnt + 1;
        else if (i_req && !o_ack)
        begin
            cnt <= 0;
            o_ack <= 1'b1;
            if (i_we)
                mem[int'(i_addr[23:1])] = i_wdata;
            else if (mem.exists(int'(i_addr[23:1])))
                o_rdata <= mem[int'(i_addr[23:1])];
        end
    end
endmodule : xfer_mem_model

// ===== transfer_ctrl_core_tb.sv
`timescale 1ns/1ps
module transfer_ctrl_core_tb;
    import transfer_ctrl_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, hw_sb = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, int_req = 8'h00, cpu_int, src_clr;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, mreq, mwe, mword, mack, irq, busy;
    logic [23:0] maddr, vaddr = 24'h0;
    logic [15:0] mwdata, mrdata;
    logic [3:0]  delay = 4'h0;
    int          errors = 0, comparisons = 0, nclr = 0;
    always #20 clk = ~clk;
    transfer_ctrl_core #(.N_SRC(8)) dut
    (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_CE(1'b1),
        .I_HW_STANDBY(hw_sb), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_INT_REQ(int_req), .O_CPU_INT(cpu_int), .O_SRC_CLR(src_clr),
        .O_MEM_REQ(mreq), .O_MEM_WE(mwe), .O_MEM_WORD(mword),
        .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwdata), .I_MEM_ACK(mack),
        .I_MEM_RDATA(mrdata), .O_IRQ(irq), .O_BUSY(busy)
    );
    xfer_mem_model mem_i
    (
        .i_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
        .i_wdata(mwdata), .i_delay(delay), .o_ack(mack), .o_rdata(mrdata)
    );
    always @(posedge clk)
    begin
        if (src_clr[0])
        begin
            int_req[0] <= 1'b0;
            nclr <= nclr + 1;
        end
        if (mreq && mack && maddr[23:8] == 16'h0004 && vaddr == 24'h0)
            vaddr <= maddr;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20)
        begin
            errors++;
            tally_and_finish();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 2000 && busy !== lvl; n++)
            @(posedge clk);
        if (busy !== lvl)
        begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_busy
    task automatic run;
        wait_busy(1'b1);
        wait_busy(1'b0);
        @(posedge clk);
    endtask : run
    task automatic desc(input logic [6:0] v, input logic [15:0] b,
                        input logic [7:0] mra, input logic [7:0] mrb,
                        input logic [15:0] dst, input logic [15:0] cra);
        int k;
        logic [15:0] w [6];
        k = int'({8'hFF, b} >> 1);
        w = '{{mra, 8'hFF}, 16'hED00, {mrb, 8'hFF}, dst, cra, 16'h0};
        mem_i.mem[int'((16'h0400 + {v, 1'b0}) >> 1)] = b;
        for (int j = 0; j < 6; j++)
            mem_i.mem[k + j] = w[j];
    endtask : desc
    function automatic logic [15:0] mget(input logic [23:0] a);
        return mem_i.mem[int'(a >> 1)];
    endfunction : mget
    initial
    begin
        logic [31:0] r;
        logic        e;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFF_MSTOP, 32'h3FFF);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(e, 32'h1);
        wr(OFF_MSTOP, 32'h0);
        hw_sb <= 1'b1;
        @(posedge clk);
        hw_sb <= 1'b0;
        @(posedge clk);
        rd(OFF_MSTOP, 32'h3FFF);
        wr(OFF_MSTOP, 32'h0);
        wr(OFF_MASK, 32'h7);
        mem_i.mem[int'(24'hFFED00 >> 1)] = 16'h1234;
        desc(7'h05, 16'hEC40, 8'hA1, 8'h00, 16'hEE00, 16'h0002);
        wr(OFF_SWVEC, 32'h85);
        run();
        chk(mget(24'hFFEE00), 16'h1234);
        chk(mget(24'hFFEC42), 16'hED02);
        chk(mget(24'hFFEC46), 16'hEE02);
        chk(mget(24'hFFEC48), 16'h0001);
        rd(OFF_SWVEC, 32'h05);
        wr(OFF_SWVEC, 32'h85);
        run();
        chk(irq, 32'h1);
        rd(OFF_SWVEC, 32'h85);
        rd(OFF_STATUS, 32'h3);
        wr(OFF_SWVEC, 32'h00);
        delay <= 4'h5;
        desc(7'h10, 16'hEC60, 8'h31, 8'h00, 16'hEF00, 16'h0002);
        wr(OFF_ENABLE, 32'h1);
        int_req[0] <= 1'b1;
        wait_busy(1'b1);
        wr(OFF_MSTOP, 32'h4000);
        rd(OFF_MSTOP, 32'h0);
        run();
        chk(nclr, 1);
        rd(OFF_ENABLE, 32'h1);
        chk(mget(24'hFFEC62), 16'hED00);
        chk(mget(24'hFFEC66), 16'hEEFE);
        int_req[0] <= 1'b1;
        run();
        chk(cpu_int, 32'h1);
        chk(nclr, 1);
        rd(OFF_ENABLE, 32'h0);
        rd(OFF_STATUS, 32'h5);
        wr(OFF_MSTOP, 32'h4000);
        wr(OFF_ENABLE, 32'h1);
        repeat (60) @(posedge clk);
        chk(busy, 32'h0);
        rd(OFF_STATE, 32'h10);
        int_req <= 8'h00;
        delay <= 4'h0;
        vaddr <= 24'h0;
        wr(OFF_MSTOP, 32'h0);
        desc(7'h11, 16'hEC80, 8'hA1, 8'h40, 16'hEF10, 16'h0005);
        desc(7'h12, 16'hECA0, 8'hA1, 8'h40, 16'hEF20, 16'h0005);
        wr(OFF_ENABLE, 32'h6);
        int_req <= 8'h06;
        for (int n = 0; n < 2000 && (cpu_int !== 8'h06 || busy); n++)
            @(posedge clk);
        chk(cpu_int, 32'h6);
        chk(vaddr, 32'h422);
        rd(OFF_ENABLE, 32'h0);
        tally_and_finish();
    end
endmodule : transfer_ctrl_core_tb
